/* File: src/tss_pkg.sv */
// Package of constants and carrier types for the tape sense status bytes.
// ==========================================================================
`default_nettype none

package tss_pkg;

  // ========================================================================
  // Sense byte layout.
  localparam int          SENSE_COUNT       = 24;
  localparam logic [4:0]  IDX_WRITE_ERRORS  = 5'h0C;
  localparam logic [4:0]  IDX_CMD_HISTORY   = 5'h0D;
  localparam logic [4:0]  IDX_MOTION_FAULT  = 5'h0E;
  localparam logic [4:0]  IDX_CHECKSUM      = 5'h0F;
  localparam logic [4:0]  IDX_ERR_ADDR_HIGH = 5'h10;
  localparam logic [4:0]  IDX_ERR_ADDR_LOW  = 5'h11;
  localparam logic [4:0]  IDX_TAPE_SENSOR   = 5'h12;
  localparam logic [4:0]  IDX_FW_REVISION   = 5'h13;
  localparam logic [4:0]  IDX_OP_PROGRESS   = 5'h14;
  localparam logic [4:0]  IDX_CART_STATE    = 5'h15;
  localparam logic [4:0]  IDX_LAST          = 5'h17;

  // ========================================================================
  // Codes, reset values and reserved masks.
  localparam logic [3:0]  CMD_SENSE_READ    = 4'h3;
  localparam logic [7:0]  HISTORY_POWER_UP  = 8'h01;
  localparam logic [7:0]  ZERO_BYTE         = 8'h00;
  localparam logic [7:0]  CHECKSUM_MASK     = 8'h01;
  localparam logic [7:0]  SENSOR_MASK       = 8'hF3;
  localparam logic [7:0]  CART_MASK         = 8'h5F;
  // Arbitrary revision value, replaced per firmware build.
  localparam logic [7:0]  FW_REVISION_DEF   = 8'h10;

  // Motion fault bit positions.
  localparam int MF_NO_TACH   = 0;
  localparam int MF_UNDER     = 1;
  localparam int MF_OVER      = 2;
  localparam int MF_TIMEOUT   = 3;
  localparam int MF_POS_LOST  = 4;
  localparam int MF_STOP      = 5;
  localparam int MF_BREAK     = 6;
  localparam int MF_MARKER    = 7;
  // Tape sensor bit positions.
  localparam int TS_BOTH_LIGHT = 0;
  localparam int TS_WARN_WRITE = 1;
  localparam int TS_END_STATE  = 4;
  localparam int TS_END_IRQ    = 5;
  localparam int TS_BEGIN_IRQ  = 6;
  localparam int TS_MARKER_IRQ = 7;

  // Fault events from the motion logic, one-cycle pulses.
  typedef struct packed {
    logic unexpected_marker;
    logic tape_break;
    logic stop_fault;
    logic position_lost;
    logic timed_check_expired;
    logic over_speed;
    logic under_speed;
    logic no_tach;
  } tss_motion_type;

  // Tape sensor events, one-cycle pulses except end_of_last_track and write_active.
  typedef struct packed {
    logic load_point_marker;
    logic tape_begin_marker;
    logic tape_end_marker;
    logic early_warning_marker;
    logic both_sensors_light;
    logic end_of_last_track;
    logic write_active;
  } tss_sensor_type;

  // Operation in progress flags, bit 7 first.
  typedef struct packed {
    logic stripe_write_active;
    logic reposition_active;
    logic reverse_step_active;
    logic file_read_active;
    logic filemark_search_active;
    logic erase_active;
    logic tach_check_active;
    logic filemark_write_active;
  } tss_ops_type;

  // Cartridge state flags as levels.
  typedef struct packed {
    logic health_check_done;
    logic long_cartridge;
    logic health_check_active;
    logic stripe_seek_active;
    logic write_enabled;
    logic cartridge_ready;
  } tss_cart_type;

endpackage : tss_pkg

`default_nettype wire

/* File: src/tss_sense_status.sv */
// Extended sense byte bank of the streaming tape controller.
`timescale 1ns/1ps
`default_nettype none

module tss_sense_status
  import tss_pkg::*;
(
  input  wire logic           ref_clk_in,
  input  wire logic           reset_n_in,
  input  wire logic           cartridge_present_in,
  input  wire logic           cmd_valid_in,
  input  wire logic [3:0]     cmd_code_in,
  input  wire tss_motion_type motion_in,
  input  wire logic           checksum_error_in,
  input  wire tss_sensor_type sensor_in,
  input  wire logic           write_error_in,
  input  wire logic [15:0]    error_address_in,
  input  wire logic           error_address_load_in,
  input  wire tss_ops_type    ops_in,
  input  wire tss_cart_type   cart_in,
  input  wire logic           sense_clear_in,
  input  wire logic           sense_start_in,
  input  wire logic           sense_next_in,
  output logic [7:0]          sense_data_out,
  output logic                sense_valid_out,
  output logic                sense_last_out,
  output logic                hard_error_flag_out,
  output logic [7:0]          command_history_out
);

  // ========================================================================
  // Storage.
  logic [7:0] write_error_counter_reg;
  logic [7:0] command_history_reg;
  logic [7:0] motion_fault_flags_reg;
  logic [7:0] checksum_fault_flags_reg;
  logic [7:0] error_address_high_reg;
  logic [7:0] error_address_low_reg;
  logic [7:0] tape_sensor_interrupt_cause_reg;
  logic [7:0] operation_in_progress_flags_reg;
  logic [7:0] cartridge_state_flags_reg;
  logic [7:0] motion_next;
  logic [7:0] sensor_next;
  logic [4:0] read_index_reg;
  logic       cart_seen_reg;

  // ========================================================================
  // Command history; sense-read commands are skipped so that the host
  // can read the history without overwriting it.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      command_history_reg <= HISTORY_POWER_UP;
      cart_seen_reg       <= 1'b0;
    end else begin
      cart_seen_reg <= cartridge_present_in;
      if (cmd_valid_in && cmd_code_in != CMD_SENSE_READ) begin
        command_history_reg <= {command_history_reg[3:0], cmd_code_in};
      end else if (!cartridge_present_in && cart_seen_reg) begin
        command_history_reg <= HISTORY_POWER_UP;
      end
    end
  end

  // ========================================================================
  // Motion faults are sticky until the sense is cleared; a new event
  // in the clearing cycle wins, so it is never lost.
  always_comb begin
    motion_next                = sense_clear_in ? ZERO_BYTE : motion_fault_flags_reg;
    motion_next[MF_NO_TACH]   |= motion_in.no_tach;
    motion_next[MF_UNDER]     |= motion_in.under_speed;
    motion_next[MF_OVER]      |= motion_in.over_speed;
    motion_next[MF_TIMEOUT]   |= motion_in.timed_check_expired;
    motion_next[MF_POS_LOST]  |= motion_in.position_lost;
    motion_next[MF_STOP]      |= motion_in.stop_fault;
    motion_next[MF_BREAK]     |= motion_in.tape_break;
    motion_next[MF_MARKER]    |= motion_in.unexpected_marker;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      motion_fault_flags_reg <= ZERO_BYTE;
    end else begin
      motion_fault_flags_reg <= motion_next;
    end
  end

  // ========================================================================
  // Tape sensor and interrupt cause byte; end state follows the level.
  always_comb begin
    sensor_next                = sense_clear_in ? ZERO_BYTE : tape_sensor_interrupt_cause_reg;
    sensor_next[TS_BOTH_LIGHT] |= sensor_in.both_sensors_light;
    sensor_next[TS_WARN_WRITE] |= sensor_in.early_warning_marker
                                  & sensor_in.write_active;
    sensor_next[TS_END_STATE]  = sensor_in.end_of_last_track;
    sensor_next[TS_END_IRQ]    |= sensor_in.tape_end_marker;
    sensor_next[TS_BEGIN_IRQ]  |= sensor_in.tape_begin_marker;
    sensor_next[TS_MARKER_IRQ] |= sensor_in.load_point_marker
                                  | sensor_in.early_warning_marker;
    sensor_next                &= SENSOR_MASK;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tape_sensor_interrupt_cause_reg <= ZERO_BYTE;
    end else begin
      tape_sensor_interrupt_cause_reg <= sensor_next;
    end
  end

  // ========================================================================
  // Checksum error and the hard error indication it raises.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      checksum_fault_flags_reg <= ZERO_BYTE;
      hard_error_flag_out      <= 1'b0;
    end else begin
      if (checksum_error_in) begin
        checksum_fault_flags_reg <= CHECKSUM_MASK;
        hard_error_flag_out      <= 1'b1;
      end else if (sense_clear_in) begin
        checksum_fault_flags_reg <= ZERO_BYTE;
        hard_error_flag_out      <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Write error counter saturates rather than wrapping to zero.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_error_counter_reg <= ZERO_BYTE;
    end else if (write_error_in && write_error_counter_reg != 8'hFF) begin
      write_error_counter_reg <= write_error_counter_reg + 8'h01;
    end else if (sense_clear_in) begin
      write_error_counter_reg <= ZERO_BYTE;
    end
  end

  // ========================================================================
  // Error address and live status bytes.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      error_address_high_reg <= ZERO_BYTE;
      error_address_low_reg  <= ZERO_BYTE;
      operation_in_progress_flags_reg <= ZERO_BYTE;
      cartridge_state_flags_reg       <= ZERO_BYTE;
    end else begin
      if (error_address_load_in) begin
        error_address_high_reg <= error_address_in[15:8];
        error_address_low_reg  <= error_address_in[7:0];
      end
      operation_in_progress_flags_reg <= ops_in;
      cartridge_state_flags_reg <= {1'b0, cart_in[5], 1'b0, cart_in[4:0]}
                                   & CART_MASK;
    end
  end

  // ========================================================================
  // Sense read port; reads only walk the index and never touch storage.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_index_reg  <= 5'h00;
      sense_valid_out <= 1'b0;
    end else if (sense_start_in) begin
      read_index_reg  <= 5'h00;
      sense_valid_out <= 1'b1;
    end else if (sense_next_in && sense_valid_out) begin
      if (read_index_reg == IDX_LAST) begin
        sense_valid_out <= 1'b0;
      end else begin
        read_index_reg <= read_index_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_data_out <= ZERO_BYTE;
      sense_last_out <= 1'b0;
    end else begin
      sense_last_out <= sense_valid_out && read_index_reg == IDX_LAST;
      case (read_index_reg)
        IDX_WRITE_ERRORS:  sense_data_out <= write_error_counter_reg;
        IDX_CMD_HISTORY:   sense_data_out <= command_history_reg;
        IDX_MOTION_FAULT:  sense_data_out <= motion_fault_flags_reg;
        IDX_CHECKSUM:      sense_data_out <= checksum_fault_flags_reg;
        IDX_ERR_ADDR_HIGH: sense_data_out <= error_address_high_reg;
        IDX_ERR_ADDR_LOW:  sense_data_out <= error_address_low_reg;
        IDX_TAPE_SENSOR:   sense_data_out <= tape_sensor_interrupt_cause_reg;
        IDX_FW_REVISION:   sense_data_out <= FW_REVISION_DEF;
        IDX_OP_PROGRESS:   sense_data_out <= operation_in_progress_flags_reg;
        IDX_CART_STATE:    sense_data_out <= cartridge_state_flags_reg;
        default:           sense_data_out <= ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      command_history_out <= HISTORY_POWER_UP;
    end else begin
      command_history_out <= command_history_reg;
    end
  end

  // ========================================================================
  // Assertions.
  sequence s_cmd_taken;
    cmd_valid_in && cmd_code_in != CMD_SENSE_READ;
  endsequence

  a_history_shift: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    s_cmd_taken |=> command_history_reg == {$past(command_history_reg[3:0]), $past(cmd_code_in)})
    else $error("Command history did not shift in the new code.");
  a_sense_skipped: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    cmd_valid_in && cmd_code_in == CMD_SENSE_READ && cartridge_present_in
    |=> $stable(command_history_reg))
    else $error("Sense read entered the command history.");
  a_no_tach_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    motion_in.no_tach |=> motion_fault_flags_reg[MF_NO_TACH])
    else $error("No tach fault not recorded.");
  a_speed_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    motion_in.under_speed |=> motion_fault_flags_reg[MF_UNDER])
    else $error("Under speed fault not recorded.");
  a_overspeed_set: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    motion_in.over_speed |=> motion_fault_flags_reg[MF_OVER])
    else $error("Over speed fault not recorded.");
  a_break_sticky: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    motion_fault_flags_reg[MF_BREAK] && !sense_clear_in |=> motion_fault_flags_reg[MF_BREAK])
    else $error("Tape break flag lost without clear.");
  a_checksum_hard: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    checksum_error_in |=> checksum_fault_flags_reg == CHECKSUM_MASK && hard_error_flag_out)
    else $error("Checksum error did not raise hard error.");
  a_sensor_reserved: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (tape_sensor_interrupt_cause_reg & ~SENSOR_MASK) == ZERO_BYTE)
    else $error("Reserved tape sensor bits set.");
  a_warn_write: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    sensor_in.early_warning_marker && sensor_in.write_active
    |=> tape_sensor_interrupt_cause_reg[TS_WARN_WRITE]
        && tape_sensor_interrupt_cause_reg[TS_MARKER_IRQ])
    else $error("Early warning during write not flagged.");
  a_read_order: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    sense_valid_out && sense_next_in && !sense_start_in && read_index_reg != IDX_LAST
    |=> read_index_reg == $past(read_index_reg) + 5'h01)
    else $error("Sense bytes not presented in ascending order.");

endmodule // tss_sense_status

`default_nettype wire

/* File: bench/tss_host_model.sv */
// Host side model that issues commands and reads back the sense bytes.
`timescale 1ns/1ps
`default_nettype none

module tss_host_model
  import tss_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] sense_data_in,
  input  wire logic       sense_valid_in,
  input  wire logic       sense_last_in,
  output var  logic       cmd_valid_out,
  output var  logic [3:0] cmd_code_out,
  output var  logic       sense_start_out,
  output var  logic       sense_next_out
);
  logic [7:0] sense_bytes [SENSE_COUNT];
  int         last_idx;
  int         valid_bad;

  // ==========================================================================
  // Requests
  // All requests start idle so nothing is taken before the bench asks.
  initial begin
    cmd_valid_out   = 1'b0;
    cmd_code_out    = 4'h0;
    sense_start_out = 1'b0;
    sense_next_out  = 1'b0;
  end

  // One command pulse, followed by an idle cycle so pulses never merge.
  task automatic issue_cmd(input logic [3:0] code);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out  <= code;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    @(posedge clk_in);
  endtask

  // Whole readout in ascending order; each byte is taken two edges after its
  // request, since the data register trails the index by one edge.
  task automatic read_all();
    last_idx  = -1;
    valid_bad = 0;
    @(posedge clk_in);
    sense_start_out <= 1'b1;
    @(posedge clk_in);
    sense_start_out <= 1'b0;
    for (int i = 0; i < SENSE_COUNT; i++) begin
      repeat (2) @(posedge clk_in);
      #1;
      sense_bytes[i] = sense_data_in;
      if (sense_valid_in !== 1'b1) valid_bad++;
      if (sense_last_in === 1'b1 && last_idx < 0) last_idx = i;
      @(posedge clk_in);
      sense_next_out <= 1'b1;
      @(posedge clk_in);
      sense_next_out <= 1'b0;
    end
    repeat (2) @(posedge clk_in);
    #1;
    if (sense_valid_in !== 1'b0) valid_bad++;
  endtask
endmodule // tss_host_model

`default_nettype wire

/* File: bench/tb_tape_sense_status_bytes.sv */
// Self-checking testbench of the tape sense status byte bank.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
  begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_tape_sense_status_bytes
  import tss_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           cart_present = 1'b0;
  logic           cmd_valid;
  logic [3:0]     cmd_code;
  tss_motion_type motion = '0;
  logic           csum_err = 1'b0;
  tss_sensor_type sensor = '0;
  logic           wr_err = 1'b0;
  logic [15:0]    err_addr = 16'h0000;
  logic           err_load = 1'b0;
  tss_ops_type    ops = '0;
  tss_cart_type   cart = '0;
  logic           clr = 1'b0;
  logic           start, next, valid, last, hard_err;
  logic [7:0]     data, hist, exp, mb;
  int             errors = 0;
  int             n_compared = 0;

  // ==========================================================================
  // Clock, device and host
  always #2 clk = ~clk;

  tss_sense_status uut (.ref_clk_in(clk), .reset_n_in(rst_n),
    .cartridge_present_in(cart_present), .cmd_valid_in(cmd_valid),
    .cmd_code_in(cmd_code), .motion_in(motion), .checksum_error_in(csum_err),
    .sensor_in(sensor), .write_error_in(wr_err), .error_address_in(err_addr),
    .error_address_load_in(err_load), .ops_in(ops), .cart_in(cart),
    .sense_clear_in(clr), .sense_start_in(start), .sense_next_in(next),
    .sense_data_out(data), .sense_valid_out(valid), .sense_last_out(last),
    .hard_error_flag_out(hard_err), .command_history_out(hist));

  tss_host_model host (.clk_in(clk), .sense_data_in(data), .sense_valid_in(valid),
    .sense_last_in(last), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
    .sense_start_out(start), .sense_next_out(next));

  // ==========================================================================
  // Helpers
  // Sticky bytes are cleared first so each event is judged on its own.
  task automatic clear_sticky();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // Power-up contents with no cartridge, and the framing of a full readout.
  task automatic t_reset();
    `CHK(hist, HISTORY_POWER_UP)
    host.read_all();
    for (int i = 0; i < SENSE_COUNT; i++) begin
      exp = (i == IDX_CMD_HISTORY) ? HISTORY_POWER_UP :
            (i == IDX_FW_REVISION) ? FW_REVISION_DEF : ZERO_BYTE;
      `CHK(host.sense_bytes[i], exp)
    end
    `CHK(host.last_idx, 23)
    `CHK(host.valid_bad, 0)
    $display("test reset finished");
  endtask

  // A sense read between two commands must not shift the history.
  task automatic t_history();
    cart_present <= 1'b1;
    host.issue_cmd(4'h5);
    host.issue_cmd(CMD_SENSE_READ);
    host.issue_cmd(4'hA);
    repeat (2) @(posedge clk);
    `CHK(hist, 8'h5A)
    host.read_all();
    `CHK(host.sense_bytes[IDX_CMD_HISTORY], 8'h5A)
    @(posedge clk);
    cart_present <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(hist, HISTORY_POWER_UP)
    $display("test history finished");
  endtask

  // Each motion fault event lands on its own bit only.
  task automatic t_motion();
    for (int b = 0; b < 8; b++) begin
      clear_sticky();
      motion <= tss_motion_type'(8'h01 << b);
      @(posedge clk);
      motion <= '0;
      host.read_all();
      exp = 8'h01 << b;
      mb = host.sense_bytes[IDX_MOTION_FAULT];
      `CHK(mb, exp)
    end
    $display("test motion finished");
  endtask

  // Checksum error raises hard error; a second readout sees the same byte.
  task automatic t_checksum();
    clear_sticky();
    csum_err <= 1'b1;
    @(posedge clk);
    csum_err <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(hard_err, 1'b1)
    repeat (2) begin
      host.read_all();
      `CHK(host.sense_bytes[IDX_CHECKSUM], CHECKSUM_MASK)
    end
    clear_sticky();
    repeat (2) @(posedge clk);
    `CHK(hard_err, 1'b0)
    $display("test checksum finished");
  endtask

  // Sensor events; the two level fields stay up through the readout.
  // Early warning with no write running must flag only the marker cause.
  task automatic t_sensor();
    logic [6:0] vec [7] = '{7'h04, 7'h02, 7'h10, 7'h20, 7'h40, 7'h49, 7'h08};
    logic [7:0] res [7] = '{8'h01, 8'h10, 8'h20, 8'h40, 8'h80, 8'h82, 8'h80};
    for (int k = 0; k < 7; k++) begin
      clear_sticky();
      sensor <= tss_sensor_type'(vec[k]);
      @(posedge clk);
      sensor <= tss_sensor_type'(vec[k] & 7'h03);
      host.read_all();
      mb = host.sense_bytes[IDX_TAPE_SENSOR];
      `CHK(mb, res[k])
      sensor <= '0;
    end
    $display("test sensor finished");
  endtask

  // Counter, error address pair and the two level bytes in one readout.
  task automatic t_misc();
    repeat (3) begin
      @(posedge clk);
      wr_err   <= 1'b1;
      err_load <= 1'b1;
      err_addr <= 16'hA55A;
      ops      <= 8'hA5;
      cart     <= 6'h2A;
      @(posedge clk);
      wr_err   <= 1'b0;
      err_load <= 1'b0;
    end
    host.read_all();
    `CHK(host.sense_bytes[IDX_WRITE_ERRORS], 8'h03)
    `CHK(host.sense_bytes[IDX_ERR_ADDR_HIGH], 8'hA5)
    `CHK(host.sense_bytes[IDX_ERR_ADDR_LOW], 8'h5A)
    `CHK(host.sense_bytes[IDX_OP_PROGRESS], 8'hA5)
    `CHK(host.sense_bytes[IDX_CART_STATE], 8'h4A)
    $display("test misc finished");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    `CHK(hist, HISTORY_POWER_UP)
    `CHK(valid, 1'b0)
    rst_n <= 1'b1;
    t_reset();
    t_history();
    t_motion();
    t_checksum();
    t_sensor();
    t_misc();
    report_and_stop();
  end

  // The whole run needs about 8 us; far beyond that counts as a hang.
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule // tb_tape_sense_status_bytes

`default_nettype wire
